// File: pwm_channel_waveform.sv
`timescale 1ns/1ps
module pwm_channel_waveform (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire pwm_pkg::addr_t    awaddr,
  // AXI4-Lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // AXI4-Lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // AXI4-Lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire pwm_pkg::addr_t    araddr,
  // AXI4-Lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // Waveform and interrupt
  output logic                   pwm_out,
  output logic                   irq
);
  import pwm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic        aw_hold;
    addr_t       aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        enabled;
    cnt_t        count;
    logic        down;
    cnt_t        duty;
    cnt_t        period;
    cnt_t        upd;
    logic        upd_valid;
    logic        align;
    logic        level;
    logic        target;
    logic [3:0]  presc;
    div_t        div_a;
    div_t        div_b;
    logic        flag;
    logic        mask;
    logic        out;
  } chan_state_t;

  chan_state_t s;
  chan_state_t next_s;

  pwm_tick_if ck ();

  pwm_clock_divider u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ck      (ck)
  );

  assign ck.presc = s.presc;
  assign ck.div_a = s.div_a;
  assign ck.div_b = s.div_b;

  function automatic logic mapped(input addr_t a);
    return a inside {OFS_CLKDIV, OFS_ENA, OFS_DIS, OFS_SR, OFS_IEN, OFS_IDIS, OFS_IMASK,
                     OFS_ISTAT, OFS_MODE, OFS_DUTY, OFS_PERIOD, OFS_COUNT, OFS_UPDATE};
  endfunction : mapped

  // ==========================================================
  // Next-state logic
  logic        wr_fire;
  logic        rd_fire;
  logic        en_cmd;
  logic        start_ev;
  logic [31:0] wv;
  logic [31:0] rv;
  logic [31:0] tv;

  always_comb begin
    next_s = s;
    wv = merge(32'h00000000, s.w_data, s.w_strb);
    tv = 32'h00000000;
    rv = 32'h00000000;
    start_ev = 1'b0;

    // Bus handshakes
    if (awvalid && awready) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_hold = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) next_s.bvalid = 1'b0;
    if (s.rvalid && rready) next_s.rvalid = 1'b0;

    wr_fire = s.aw_hold && s.w_hold && !s.bvalid;
    rd_fire = arvalid && arready;
    en_cmd  = wr_fire && s.aw_addr == OFS_ENA && wv[CH_BIT];

    // Channel counter
    if (en_cmd) begin
      next_s.enabled = 1'b1;
      next_s.count = CNT_RST;
      next_s.down = 1'b0;
    end else if (s.enabled && ck.tick) begin
      if (s.period == CNT_RST) begin
        next_s.count = CNT_RST;
        start_ev = 1'b1;
      end else if (!s.align) begin
        if (s.count + 20'h00001 >= s.period) begin
          next_s.count = CNT_RST;
          start_ev = 1'b1;
        end else begin
          next_s.count = s.count + 20'h00001;
        end
      end else if (!s.down) begin
        // Up ramp and down ramp each take period ticks
        next_s.count = s.count + 20'h00001;
        if (s.count + 20'h00001 >= s.period) next_s.down = 1'b1;
      end else begin
        next_s.count = s.count - 20'h00001;
        if (s.count == 20'h00001 || s.count == CNT_RST) begin
          next_s.down = 1'b0;
          start_ev = 1'b1;
        end
      end
    end

    // Buffered value lands only at a period boundary
    if (start_ev && s.upd_valid) begin
      next_s.upd_valid = 1'b0;
      if (s.target) next_s.period = s.upd;
      else next_s.duty = s.upd;
    end
    if (start_ev) next_s.flag = 1'b1;

    // Register writes
    if (wr_fire) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s.aw_addr)
        OFS_CLKDIV: begin
          tv = merge({8'h00, s.div_b, 8'h00, s.div_a}, s.w_data, s.w_strb);
          next_s.div_a = tv[DIVIDER_A_LSB+:DIV_W];
          next_s.div_b = tv[DIVIDER_B_LSB+:DIV_W];
        end
        OFS_DIS: if (wv[CH_BIT]) next_s.enabled = 1'b0;
        OFS_IEN: if (wv[CH_BIT]) next_s.mask = 1'b1;
        OFS_IDIS: if (wv[CH_BIT]) next_s.mask = 1'b0;
        // Write-one clear; a period event in the same cycle wins
        OFS_ISTAT: if (wv[CH_BIT] && !start_ev) next_s.flag = 1'b0;
        OFS_MODE: begin
          rv = merge({21'h000000, s.target, s.level, s.align, 4'h0, s.presc}, s.w_data, s.w_strb);
          next_s.presc = rv[MODE_PRESC_LSB+:4];
          next_s.align = rv[MODE_ALIGN_BIT];
          next_s.level = rv[MODE_LEVEL_BIT];
          next_s.target = rv[MODE_TGT_BIT];
        end
        OFS_DUTY: begin
          tv = merge({12'h000, s.duty}, s.w_data, s.w_strb);
          next_s.duty = tv[CNT_W-1:0];
        end
        OFS_PERIOD: begin
          tv = merge({12'h000, s.period}, s.w_data, s.w_strb);
          next_s.period = tv[CNT_W-1:0];
        end
        OFS_UPDATE: begin
          // Upper twelve bits are dropped here, never stored
          tv = merge({12'h000, s.upd}, s.w_data, s.w_strb);
          next_s.upd = tv[CNT_W-1:0];
          next_s.upd_valid = 1'b1;
        end
        default: ; // Counter and status words ignore writes
      endcase
    end

    // Register reads
    rv = 32'h00000000;
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        OFS_CLKDIV: rv = {8'h00, s.div_b, 8'h00, s.div_a};
        OFS_SR:     rv[CH_BIT] = s.enabled;
        OFS_IMASK:  rv[CH_BIT] = s.mask;
        OFS_ISTAT: begin
          rv[CH_BIT] = s.flag;
          // Reading clears, but a fresh event must survive the read
          if (!start_ev) next_s.flag = 1'b0;
        end
        OFS_MODE:   rv = {21'h000000, s.target, s.level, s.align, 4'h0, s.presc};
        OFS_DUTY:   rv = {12'h000, s.duty};
        OFS_PERIOD: rv = {12'h000, s.period};
        OFS_COUNT:  rv = {12'h000, s.count};
        default:    rv = 32'h00000000;
      endcase
      next_s.rdata = rv;
    end

    // Output level follows the registered counter
    if (!next_s.enabled) next_s.out = next_s.level;
    else if (next_s.count < next_s.duty) next_s.out = next_s.level;
    else next_s.out = !next_s.level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign awready = !s.aw_hold && !s.bvalid;
  assign wready  = !s.w_hold && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign pwm_out = s.out;
  assign irq     = s.flag && s.mask;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_enable_clears: assert property (en_cmd |=> s.count == CNT_RST && s.enabled)
    else $error("enable command did not clear the counter");

  chk_left_wrap: assert property (
    s.enabled && ck.tick && !s.align && s.period != CNT_RST && s.count + 20'h00001 >= s.period
    |=> s.count == CNT_RST)
    else $error("left-aligned counter did not clear at period");

  chk_center_turn: assert property (
    s.enabled && ck.tick && s.align && !s.down && !en_cmd && s.period != CNT_RST
    && s.count + 20'h00001 >= s.period |=> s.down && s.count == $past(s.period))
    else $error("center-aligned counter did not turn at period");

  chk_update_hold: assert property (
    s.upd_valid && !start_ev && !wr_fire |=> $stable(s.duty) && $stable(s.period))
    else $error("buffered update applied outside a period start");

  chk_update_duty: assert property (
    start_ev && s.upd_valid && !s.target && !wr_fire |=> s.duty == $past(s.upd) && !s.upd_valid)
    else $error("update value not moved into duty at period start");

  chk_event_flag: assert property (start_ev |=> s.flag ##0 irq == s.mask)
    else $error("period event did not raise the status flag");

  chk_mask_set: assert property (
    wr_fire && s.aw_addr == OFS_IEN && wv[CH_BIT] |=> s.mask)
    else $error("interrupt enable write did not set the mask");

  chk_count_ro: assert property (
    wr_fire && s.aw_addr == OFS_COUNT && !s.enabled |=> $stable(s.count))
    else $error("counter changed on a bus write");

  chk_duty_width: assert property (
    wr_fire && s.aw_addr == OFS_DUTY && s.w_strb == 4'hf && !start_ev
    |=> s.duty == $past(s.w_data[CNT_W-1:0]))
    else $error("duty register did not keep the low 20 bits");

  chk_out_level: assert property (
    s.enabled && $stable(s.count) && $stable(s.duty) && $stable(s.level)
    |-> pwm_out == (s.count < s.duty ? s.level : !s.level))
    else $error("output level does not follow counter against duty");

  chk_flag_rd_clear: assert property (
    rd_fire && araddr == OFS_ISTAT && !start_ev |=> !s.flag)
    else $error("status read did not clear the period flag");

  chk_flag_rd_data: assert property (
    rd_fire && araddr == OFS_ISTAT |=> rdata[CH_BIT] == $past(s.flag))
    else $error("status read returned the wrong flag value");

  chk_update_period: assert property (
    start_ev && s.upd_valid && s.target && !wr_fire |=> s.period == $past(s.upd) && !s.upd_valid)
    else $error("update value not moved into period at period start");

  chk_center_bottom: assert property (
    s.enabled && ck.tick && s.align && s.down && !en_cmd && s.period != CNT_RST
    && s.count == 20'h00001 |=> !s.down && s.count == CNT_RST)
    else $error("center-aligned counter did not turn at zero");

  chk_count_frozen: assert property (
    !s.enabled && !en_cmd |=> $stable(s.count))
    else $error("counter moved while the channel was disabled");

  chk_disabled_level: assert property (
    !s.enabled && !en_cmd |=> pwm_out == s.level)
    else $error("disabled output does not rest at the start level");

  chk_mask_keep: assert property (
    wr_fire && s.aw_addr == OFS_IEN && !wv[CH_BIT] |=> s.mask == $past(s.mask))
    else $error("interrupt enable write of zero changed the mask");

  chk_mask_clear: assert property (
    wr_fire && s.aw_addr == OFS_IDIS && wv[CH_BIT] |=> !s.mask)
    else $error("interrupt disable write did not clear the mask");

  cov_left_period: cover property (start_ev && !s.align && s.enabled);
  cov_center_period: cover property (start_ev && s.align ##1 s.flag);
  cov_update_period: cover property (start_ev && s.upd_valid && s.target);
  cov_irq_raised: cover property (!irq ##1 irq);
  cov_flag_read: cover property (rd_fire && araddr == OFS_ISTAT && s.flag);

endmodule : pwm_channel_waveform

// File: pwm_pkg.sv
// Notes on behaviour
// - Alignment bit: 0 left, 1 center
// - Start level bit: 0 low, 1 high
// - Update target: 0 duty, 1 period
// - Duty, period, update, counter hold 20 bits
// - Left period equals period times divisor
// - Center period is twice that
// - Counter may run from divider A or B
// - Enable command clears the counter
// - Left mode: counter clears at period value
// - Counter is readable, never writable
// - Update value applied only at period start
// - Period event flag; status read clears it
// - Writing one to interrupt enable register sets mask
package pwm_pkg;

  // ==========================================================
  // Widths and types
  localparam int CNT_W  = 20;
  localparam int ADDR_W = 12;
  localparam int DIV_W  = 8;
  typedef logic [CNT_W-1:0]  cnt_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DIV_W-1:0]  div_t;

  // ==========================================================
  // Register offsets
  localparam addr_t OFS_CLKDIV = 12'h000;
  localparam addr_t OFS_ENA    = 12'h004;
  localparam addr_t OFS_DIS    = 12'h008;
  localparam addr_t OFS_SR     = 12'h00c;
  localparam addr_t OFS_IEN    = 12'h010;
  localparam addr_t OFS_IDIS   = 12'h014;
  localparam addr_t OFS_IMASK  = 12'h018;
  localparam addr_t OFS_ISTAT  = 12'h01c;
  localparam addr_t OFS_MODE   = 12'h200;
  localparam addr_t OFS_DUTY   = 12'h204;
  localparam addr_t OFS_PERIOD = 12'h208;
  localparam addr_t OFS_COUNT  = 12'h20c;
  localparam addr_t OFS_UPDATE = 12'h210;

  // ==========================================================
  // Field positions
  localparam int MODE_PRESC_LSB = 0;
  localparam int MODE_ALIGN_BIT = 8;
  localparam int MODE_LEVEL_BIT = 9;
  localparam int MODE_TGT_BIT   = 10;
  localparam int DIVIDER_A_LSB       = 0;
  localparam int DIVIDER_B_LSB       = 16;
  localparam int CH_BIT         = 0;

  // ==========================================================
  // Prescaler codes and reset values
  localparam logic [3:0] PRESC_MAX_POW = 4'ha;
  localparam logic [3:0] PRESC_DIV_A   = 4'hb;
  localparam logic [3:0] PRESC_DIV_B   = 4'hc;
  localparam logic [3:0] PRESC_RST     = 4'h0;
  localparam cnt_t       CNT_RST       = 20'h00000;
  localparam div_t       DIV_RST       = 8'h00;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i+:8] = data[8*i+:8];
    end
    return r;
  endfunction : merge

endpackage : pwm_pkg

// File: pwm_tick_if.sv
`timescale 1ns/1ps
interface pwm_tick_if;
  logic [3:0]   presc;
  pwm_pkg::div_t div_a;
  pwm_pkg::div_t div_b;
  logic         tick;
  modport src  (input presc, input div_a, input div_b, output tick);
  modport user (output presc, output div_a, output div_b, input tick);
endinterface : pwm_tick_if

// File: pwm_clock_divider.sv
`timescale 1ns/1ps
module pwm_clock_divider (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick selection
  pwm_tick_if.src   ck
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [9:0] pow_cnt;
    div_t       a_cnt;
    div_t       b_cnt;
    logic       tick;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  function automatic div_t step(input div_t c, input div_t d);
    if (d == DIV_RST || c >= d - 8'h01) return DIV_RST;
    return c + 8'h01;
  endfunction : step

  always_comb begin
    logic [9:0] mask;
    mask = 10'h000;
    next_s = s;
    next_s.pow_cnt = s.pow_cnt + 10'h001;
    next_s.a_cnt = step(s.a_cnt, ck.div_a);
    next_s.b_cnt = step(s.b_cnt, ck.div_b);
    // Power-of-two taps share one free counter, so phase is arbitrary
    if (ck.presc <= PRESC_MAX_POW) begin
      mask = 10'((11'h001 << ck.presc) - 11'h001);
      next_s.tick = (s.pow_cnt & mask) == mask;
    end else if (ck.presc == PRESC_DIV_A) begin
      next_s.tick = ck.div_a != DIV_RST && next_s.a_cnt == DIV_RST;
    end else if (ck.presc == PRESC_DIV_B) begin
      next_s.tick = ck.div_b != DIV_RST && next_s.b_cnt == DIV_RST;
    end else begin
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ck.tick = s.tick;

endmodule : pwm_clock_divider

// File: pwm_load_model.sv
`timescale 1ns/1ps
module pwm_load_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Waveform seen by the load
  input  wire logic pwm_out,
  // Last whole period, measured from one rise to the next
  output int        period_cycles,
  output int        high_cycles
);
  logic prev_level;
  int   run;
  int   hi;

  // ==========================================================
  // Rise-to-rise measurement; the load only listens
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level    <= 1'b0;
      run           <= 0;
      hi            <= 0;
      period_cycles <= 0;
      high_cycles   <= 0;
    end else begin
      prev_level <= pwm_out;
      run        <= run + 1;
      hi         <= hi + int'(pwm_out);
      if (pwm_out && !prev_level) begin
        period_cycles <= run;
        high_cycles   <= hi;
        run           <= 1;
        hi            <= 1;
      end
    end
  end
endmodule : pwm_load_model

// File: pwm_channel_waveform_tb.sv
`timescale 1ns/1ps
module pwm_channel_waveform_tb;
  import pwm_pkg::*;
  localparam addr_t EN_CMD = 12'h004;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  addr_t awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pwm_out, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int period_cycles, high_cycles, errors = 0, total_checks = 0, cycles = 0;

  always #2 aclk = ~aclk;

  pwm_channel_waveform pwm_channel_waveform_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .pwm_out(pwm_out), .irq(irq));
  pwm_load_model pwm_load_model_i (.aclk(aclk), .aresetn(aresetn), .pwm_out(pwm_out),
    .period_cycles(period_cycles), .high_cycles(high_cycles));

  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report;
    end
  end

  // ==========================================================
  // Bus tasks; handshakes judged at the falling edge, where nothing moves
  task automatic wr(input addr_t a, input logic [31:0] d, output logic [1:0] r);
    logic a_hs, w_hs, b_hs;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
    do begin
      @(negedge aclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input addr_t a, output logic [31:0] d, output logic [1:0] r);
    logic a_hs, r_hs;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(negedge aclk);
      a_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_hs) arvalid <= 1'b0;
    end while (!r_hs);
    rready <= 1'b0;
  endtask : rd

  task automatic wr_ok(input addr_t a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr_ok

  task automatic rd_chk(input string name, input addr_t a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(name, d, exp);
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic reset_and_map;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("duty_rst", OFS_DUTY, 32'h0);
    rd_chk("period_rst", OFS_PERIOD, 32'h0);
    rd_chk("count_rst", OFS_COUNT, 32'h0);
    rd_chk("mode_rst", OFS_MODE, 32'h0);
    rd(12'h7f0, d, r);
    check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr_ok(OFS_COUNT, 32'h00000055);
    rd_chk("count_ro", OFS_COUNT, 32'h0);
  endtask : reset_and_map

  task automatic waveform_modes;
    logic [31:0] modes [6] = '{32'h000, 32'h200, 32'h001, 32'h00b, 32'h00c, 32'h100};
    int per [6] = '{8, 8, 16, 24, 16, 16};
    int hi [6] = '{5, 3, 10, 15, 10, 11};
    wr_ok(OFS_CLKDIV, 32'h00020003);
    rd_chk("div_word", OFS_CLKDIV, 32'h00020003);
    wr_ok(OFS_PERIOD, 32'h00000008);
    wr_ok(OFS_DUTY, 32'h00000003);
    for (int i = 0; i < 6; i++) begin
      wr_ok(OFS_MODE, modes[i]);
      wr_ok(EN_CMD, 32'h1);
      repeat (100) @(posedge aclk);
      check("period", period_cycles, per[i]);
      if (hi[i] >= 0) check("high_time", high_cycles, hi[i]);
    end
  endtask : waveform_modes

  task automatic update_buffer;
    wr_ok(OFS_MODE, 32'h000);
    wr_ok(OFS_DIS, 32'h1);
    wr_ok(OFS_UPDATE, 32'hfff00005);
    rd_chk("update_wo", OFS_UPDATE, 32'h0);
    rd_chk("duty_held", OFS_DUTY, 32'h3);
    wr_ok(EN_CMD, 32'h1);
    repeat (30) @(posedge aclk);
    rd_chk("duty_upd", OFS_DUTY, 32'h5);
    wr_ok(OFS_DIS, 32'h1);
    wr_ok(OFS_MODE, 32'h400);
    wr_ok(OFS_UPDATE, 32'h0000000c);
    rd_chk("period_held", OFS_PERIOD, 32'h8);
    wr_ok(EN_CMD, 32'h1);
    repeat (60) @(posedge aclk);
    rd_chk("period_upd", OFS_PERIOD, 32'hc);
    check("period_new", period_cycles, 12);
  endtask : update_buffer

  task automatic enable_clears;
    logic [31:0] d;
    logic [1:0] r;
    wr_ok(OFS_MODE, 32'h000);
    wr_ok(OFS_PERIOD, 32'h00000400);
    wr_ok(EN_CMD, 32'h1);
    repeat (300) @(posedge aclk);
    wr_ok(OFS_DIS, 32'h1);
    rd(OFS_COUNT, d, r);
    check("count_run", {31'h0, d > 32'd200}, 32'h1);
    wr_ok(EN_CMD, 32'h1);
    wr_ok(OFS_DIS, 32'h1);
    rd(OFS_COUNT, d, r);
    check("count_clr", {31'h0, d < 32'd20}, 32'h1);
  endtask : enable_clears

  task automatic interrupt_flow;
    // Flag still holds events from earlier scenarios; clear it first
    rd_chk("flag_old", OFS_ISTAT, 32'h1);
    rd_chk("flag_idle", OFS_ISTAT, 32'h0);
    wr_ok(OFS_PERIOD, 32'h00000008);
    wr_ok(OFS_IEN, 32'h0);
    rd_chk("mask_w0", OFS_IMASK, 32'h0);
    wr_ok(OFS_IEN, 32'h1);
    rd_chk("mask_set", OFS_IMASK, 32'h1);
    @(negedge aclk);
    check("irq_idle", {31'h0, irq}, 32'h0);
    wr_ok(EN_CMD, 32'h1);
    rd_chk("enabled_on", OFS_SR, 32'h1);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    check("irq_high", {31'h0, irq}, 32'h1);
    wr_ok(OFS_DIS, 32'h1);
    rd_chk("enabled_off", OFS_SR, 32'h0);
    rd_chk("flag_set", OFS_ISTAT, 32'h1);
    rd_chk("flag_clr", OFS_ISTAT, 32'h0);
    @(negedge aclk);
    check("irq_low", {31'h0, irq}, 32'h0);
    wr_ok(EN_CMD, 32'h1);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    check("irq_again", {31'h0, irq}, 32'h1);
    wr_ok(OFS_DIS, 32'h1);
    wr_ok(OFS_ISTAT, 32'h1);
    rd_chk("flag_w1c", OFS_ISTAT, 32'h0);
    wr_ok(OFS_IDIS, 32'h1);
    rd_chk("mask_clr", OFS_IMASK, 32'h0);
  endtask : interrupt_flow

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    reset_and_map();
    waveform_modes();
    update_buffer();
    enable_clears();
    interrupt_flow();
    final_report();
  end
endmodule : pwm_channel_waveform_tb
